// ---- include/smc_arb_if.sv ----
// interface: address arbiter handshake inside the controller
`timescale 1ns/100ps
interface smc_arb_if;
  logic [1:0] req; // synchronised requests, active high
  logic hold; // tenure under way, keep grant
  logic ack; // tenure acknowledged, free bus
  logic [1:0] grant; // one hot address grant
  logic tag; // master number of the grant
  modport arb (input req, input hold, input ack, output grant, output tag);
  modport ctl (output req, output hold, output ack, input grant, input tag);
endinterface

// ---- include/smc_pkg.sv ----
// package: constants and types of the split bus memory controller
package smc_pkg;
  // timing, 40 MHz clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int FLASH_ACCESS_NS = 70;
  localparam int FLASH_WAIT_CYC =
    (FLASH_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_DEPTH = 2;
  localparam int FLASH_CAP_CYC = FLASH_WAIT_CYC + SYNC_DEPTH;
  localparam int SRAM_RD_CYC = 1 + SYNC_DEPTH;
  localparam int WR_SETTLE_CYC = 1 + SYNC_DEPTH;
  localparam int ARTRY_WAIT_CYC = 2 + SYNC_DEPTH;
  localparam int BURST_BEATS = 4;
  localparam int FLASH_HW_PER_WORD = 4;
  // memory map and reset vector
  localparam logic [31:0] FLASH_BASE = 32'hFFF0_0000;
  localparam logic [31:0] FLASH_LAST = 32'hFFF7_FFFF;
  localparam logic [31:0] SRAM_BASE = 32'h4000_0000;
  localparam logic [31:0] SRAM_LAST = 32'h400F_FFFF;
  localparam logic [31:0] RESET_VECTOR = 32'hFFF0_0100;
  // memory geometry and address fields
  localparam int MEM_AW = 18;
  localparam int MEM_DW = 72;
  localparam int SRAM_A_FIRST = 11;
  localparam int SRAM_A_LAST = 28;
  localparam int FLASH_A_FIRST = 13;
  localparam int FLASH_A_LAST = 28;
  // transfer types that move data
  localparam logic [4:0] TT_WR_FLUSH = 5'h02;
  localparam logic [4:0] TT_WR_KILL = 5'h06;
  localparam logic [4:0] TT_RD = 5'h0A;
  localparam logic [4:0] TT_RD_NC = 5'h0B;
  localparam logic [4:0] TT_RD_MOD = 5'h0E;
  localparam logic [4:0] TT_WR_ATOM = 5'h12;
  localparam logic [4:0] TT_WR_CTL = 5'h14;
  localparam logic [4:0] TT_RD_ATOM = 5'h1A;
  localparam logic [4:0] TT_RD_CTL = 5'h1C;
  // data engine states
  typedef enum logic [1:0] {ST_IDLE, ST_SRD, ST_SWR, ST_FRD} smc_state_t;
endpackage

// ---- rtl/smc_addr_arb.sv ----
// module: round robin address bus arbiter for two masters
`timescale 1ns/100ps
module smc_addr_arb
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // handshake with controller
  smc_arb_if.arb bus
);
  logic [1:0] grant_q; // current grant
  logic last_q; // master granted last
  logic [1:0] pick; // candidate grant
  logic drop; // grant may be withdrawn

  ////////////////////////////////////////////////////////////////////////
  // alternate on contention so neither master starves
  assign pick = (bus.req == 2'b11) ? (last_q ? 2'b01 : 2'b10) : bus.req;
  // lost request without tenure frees the bus
  assign drop = bus.ack | (~|(bus.req & grant_q) & ~bus.hold);
  assign bus.grant = grant_q;
  assign bus.tag = grant_q[1];

  // grant register, one at a time
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      grant_q <= 2'b00;
      last_q <= 1'b1;
    end
    else if (grant_q != 2'b00)
    begin
      if (drop)
        grant_q <= 2'b00; // idle cycle between grants
    end
    else if (pick != 2'b00)
    begin
      grant_q <= pick;
      last_q <= pick[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  grant_onehot_a: assert property (grant_q != 2'b11)
    else $error("both address grants active");
  grant_alt_a: assert property ((grant_q == 2'b00 && bus.req == 2'b11
    && last_q) |=> grant_q == 2'b01)
    else $error("contention not alternated");
  cover_contend: cover property (bus.req == 2'b11 && grant_q == 2'b00);
endmodule // smc_addr_arb

// ---- rtl/smc_flash_rd.sv ----
// module: flash read engine assembling four halfwords into a bus word
`timescale 1ns/100ps
module smc_flash_rd
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // request from data engine
  input wire logic start,
  input wire logic [15:0] hw_base,
  input wire logic [15:0] mem_rd,
  output logic done_q,
  output logic [smc_pkg::MEM_DW-1:0] word,
  // flash pins
  output logic [smc_pkg::MEM_AW-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n
);
  import smc_pkg::*;
  logic busy_q; // read in progress
  logic [2:0] cnt_q; // access wait counter
  logic [1:0] idx_q; // halfword index
  logic [15:0] base_q; // word address held
  logic [63:0] asm_q; // assembled data
  logic [0:7] par; // odd parity per byte

  ////////////////////////////////////////////////////////////////////////
  // odd parity so the bus sees the same code as sram data
  for (genvar k = 0; k < 8; k++)
  begin : g_par
    assign par[k] = ~^asm_q[63-8*k -: 8];
  end
  assign word = {par, asm_q};

  // first halfword lands most significant, no burst mode used
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_q <= 1'b0;
      cnt_q <= 3'h0;
      idx_q <= 2'h0;
      base_q <= 16'h0000;
      asm_q <= 64'h0000_0000_0000_0000;
      done_q <= 1'b0;
      flash_addr <= 18'h0_0000;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end
    else
    begin
      done_q <= 1'b0;
      if (start && !busy_q)
      begin
        busy_q <= 1'b1;
        cnt_q <= 3'h0;
        idx_q <= 2'h0;
        base_q <= hw_base;
        flash_addr <= {hw_base, 2'b00};
        flash_ce_n <= 1'b0;
        flash_oe_n <= 1'b0;
      end
      else if (busy_q)
      begin
        if (cnt_q == 3'(FLASH_CAP_CYC))
        begin
          asm_q <= {asm_q[47:0], mem_rd};
          cnt_q <= 3'h0;
          if (idx_q == 2'(FLASH_HW_PER_WORD - 1))
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
          end
          else
          begin
            idx_q <= idx_q + 2'h1;
            flash_addr <= {base_q, idx_q + 2'h1};
          end
        end
        else
          cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  localparam int FL_TOTAL = 4 * (FLASH_CAP_CYC + 1) + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  flash_len_a: assert property ((start && !busy_q) |-> ##FL_TOTAL done_q)
    else $error("flash word not assembled in time");
endmodule // smc_flash_rd

// ---- rtl/smc_top.sv ----
// module: split bus memory controller top, two masters to sram and flash
`timescale 1ns/100ps
module smc_top
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // address arbitration
  input wire logic addr_req_master0_n,
  input wire logic addr_req_master1_n,
  output logic addr_grant_master0_n,
  output logic addr_grant_master1_n,
  // address tenure
  input wire logic ts_n,
  input wire logic [0:4] tt,
  input wire logic [0:2] tsiz,
  input wire logic tbst_n,
  input wire logic [0:31] addr,
  input wire logic artry_n,
  output logic aack_n,
  // data tenure
  output logic data_grant_master0_n,
  output logic data_grant_master1_n,
  output logic ta_n,
  input wire logic [0:31] data_upper_word_i,
  input wire logic [0:31] data_lower_word_i,
  input wire logic [0:7] data_par_i,
  output logic [0:31] data_upper_word_o,
  output logic [0:31] data_lower_word_o,
  output logic [0:7] data_par_o,
  output logic data_oe,
  // sram
  output logic [smc_pkg::MEM_AW-1:0] sram_addr,
  output logic sram_adsc_n,
  output logic sram_adv_n,
  output logic [0:7] sram_bw_n,
  output logic sram_gw_n,
  output logic sram_oe_n,
  // shared memory data bus
  input wire logic [smc_pkg::MEM_DW-1:0] mem_data_i,
  output logic [smc_pkg::MEM_DW-1:0] mem_data_o,
  output logic mem_data_oe,
  // flash
  output logic [smc_pkg::MEM_AW-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  import smc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, bus pins arrive from outside the clock domain
  logic [44:0] pin_raw; // packed control and address pins
  logic [44:0] pin_s1_q; // first stage, read only by second
  logic [44:0] pin_s2_q; // usable stage
  logic [MEM_DW-1:0] din_s1_q; // processor data first stage
  logic [MEM_DW-1:0] din_s2_q; // processor data usable
  logic [MEM_DW-1:0] mem_s1_q; // memory data first stage
  logic [MEM_DW-1:0] mem_s2_q; // memory data usable
  assign pin_raw = {addr_req_master0_n, addr_req_master1_n, ts_n, tt,
    tsiz, tbst_n, addr, artry_n};

  // one clock, one synchronous reset for every stage
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      din_s1_q <= '0;
      din_s2_q <= '0;
      mem_s1_q <= '0;
      mem_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      din_s1_q <= {data_par_i, data_upper_word_i, data_lower_word_i};
      din_s2_q <= din_s1_q;
      mem_s1_q <= mem_data_i;
      mem_s2_q <= mem_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // unpacked synchronised pins, active high where named so
  logic s_req0, s_req1, s_ts, s_burst, s_artry;
  logic [4:0] s_tt;
  logic [2:0] s_tsiz;
  logic [0:31] s_addr; // bit 0 most significant
  assign s_req0 = ~pin_s2_q[44];
  assign s_req1 = ~pin_s2_q[43];
  assign s_ts = ~pin_s2_q[42];
  assign s_tt = pin_s2_q[41:37];
  assign s_tsiz = pin_s2_q[36:34];
  assign s_burst = ~pin_s2_q[33];
  assign s_addr = pin_s2_q[32:1];
  assign s_artry = ~pin_s2_q[0];

  ////////////////////////////////////////////////////////////////////////
  // address decode
  logic dec_rd, dec_wr, dec_aonly, in_flash, in_sram, dec_valid;
  logic [0:7] dec_lanes; // byte lanes, lane 0 most significant
  assign dec_rd = (s_tt == TT_RD) | (s_tt == TT_RD_NC) | (s_tt == TT_RD_MOD)
    | (s_tt == TT_RD_ATOM) | (s_tt == TT_RD_CTL);
  assign dec_wr = (s_tt == TT_WR_FLUSH) | (s_tt == TT_WR_KILL)
    | (s_tt == TT_WR_ATOM) | (s_tt == TT_WR_CTL);
  assign dec_aonly = ~dec_rd & ~dec_wr;
  // the reset vector falls inside this window
  assign in_flash = (s_addr >= FLASH_BASE) && (s_addr <= FLASH_LAST);
  assign in_sram = (s_addr >= SRAM_BASE) && (s_addr <= SRAM_LAST);
  // flash writes and bursts are not ours, left unacknowledged
  assign dec_valid = dec_aonly | (in_sram & (dec_rd | dec_wr))
    | (in_flash & dec_rd & ~s_burst);

  // lanes from offset and size; misaligned spill is split by the master
  function automatic logic [0:7] smc_lanes(input logic [2:0] off,
    input logic [2:0] sz, input logic burst);
    logic [3:0] n;
    logic [0:7] m;
    n = (sz == 3'h0) ? 4'h8 : {1'b0, sz};
    for (int k = 0; k < 8; k++)
      m[k] = burst | ((4'(k) >= {1'b0, off}) && (4'(k) < {1'b0, off} + n));
    return m;
  endfunction
  assign dec_lanes = smc_lanes(s_addr[29:31], s_tsiz, s_burst);

  ////////////////////////////////////////////////////////////////////////
  // arbiter hookup
  smc_arb_if arb_bus();
  logic tenure_q, stage_v_q; // open tenure, staged data transfer
  logic ten_any; // tenure visible this cycle
  logic ack_go; // acknowledge now
  assign ten_any = s_ts | tenure_q;
  assign arb_bus.req = {s_req1, s_req0};
  assign arb_bus.hold = ten_any;
  assign arb_bus.ack = ack_go;
  smc_addr_arb u_arb (
    .clk(clk),
    .reset(reset),
    .bus(arb_bus.arb)
  );

  // data tenures wait for a free stage, address only ones never do
  assign ack_go = ten_any & dec_valid & aack_n
    & (dec_aonly | ~stage_v_q);

  // grant pins and address acknowledge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      addr_grant_master0_n <= 1'b1;
      addr_grant_master1_n <= 1'b1;
      aack_n <= 1'b1;
      tenure_q <= 1'b0;
    end
    else
    begin
      addr_grant_master0_n <= ~arb_bus.grant[0];
      addr_grant_master1_n <= ~arb_bus.grant[1];
      aack_n <= ~ack_go;
      // unmapped cycle is dropped for another device to answer
      tenure_q <= (ack_go | (ten_any & ~dec_valid)) ? 1'b0 : ten_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one deep stage between address and data tenures
  smc_state_t state_q; // data engine state
  logic stg_rd_q, stg_fl_q, stg_burst_q, stg_tag_q;
  logic [0:31] stg_addr_q; // held address
  logic [0:7] stg_lanes_q; // held byte lanes
  logic [2:0] art_cnt_q; // retry window counter
  logic launch; // stage moves to data engine
  logic art_open; // retry may still arrive
  assign art_open = art_cnt_q != 3'(ARTRY_WAIT_CYC);
  assign launch = stage_v_q & ~art_open & (state_q == ST_IDLE);

  // a stored start stands for the data bus request
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage_v_q <= 1'b0;
      art_cnt_q <= 3'h0;
      {stg_rd_q, stg_fl_q, stg_burst_q, stg_tag_q} <= 4'h0;
      stg_addr_q <= 32'h0000_0000;
      stg_lanes_q <= 8'h00;
    end
    else if (ack_go & ~dec_aonly)
    begin
      stage_v_q <= 1'b1;
      art_cnt_q <= 3'h0;
      stg_rd_q <= dec_rd;
      stg_fl_q <= in_flash;
      stg_burst_q <= s_burst;
      stg_tag_q <= arb_bus.tag;
      stg_addr_q <= s_addr;
      stg_lanes_q <= dec_lanes;
    end
    else if (stage_v_q)
    begin
      // retry costs the window of latency on every transfer
      if (s_artry & art_open)
        stage_v_q <= 1'b0;
      else if (launch)
        stage_v_q <= 1'b0;
      else if (art_open)
        art_cnt_q <= art_cnt_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flash read engine
  logic fl_start_q; // start pulse
  logic fl_done; // word assembled
  logic [MEM_DW-1:0] fl_word; // word with parity
  smc_flash_rd u_flash (
    .clk(clk),
    .reset(reset),
    .start(fl_start_q),
    .hw_base(stg_addr_q[FLASH_A_FIRST:FLASH_A_LAST]),
    .mem_rd(mem_s2_q[63:48]),
    .done_q(fl_done),
    .word(fl_word),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // data engine
  logic [2:0] cnt_q; // beat wait counter
  logic [1:0] beat_q; // beat number
  logic first_q; // first sram strobe pending
  logic act_burst_q; // active transfer is a burst
  logic [0:7] act_lanes_q; // active byte lanes
  logic last_beat; // current beat ends tenure
  assign last_beat = beat_q == (act_burst_q ? 2'(BURST_BEATS - 1) : 2'h0);

  // grants, beats and memory strobes; no busy handshake is used
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      {cnt_q, beat_q, first_q, act_burst_q, fl_start_q} <= 8'h00;
      act_lanes_q <= 8'h00;
      {data_grant_master0_n, data_grant_master1_n, ta_n} <= 3'h7;
      {data_upper_word_o, data_lower_word_o, data_par_o} <= '0;
      data_oe <= 1'b0;
      {sram_adsc_n, sram_adv_n, sram_gw_n, sram_oe_n} <= 4'hF;
      sram_addr <= 18'h0_0000;
      sram_bw_n <= 8'hFF;
      mem_data_o <= '0;
      mem_data_oe <= 1'b0;
    end
    else
    begin
      // strobes default inactive each cycle
      {data_grant_master0_n, data_grant_master1_n, ta_n} <= 3'h7;
      {sram_adsc_n, sram_adv_n} <= 2'h3;
      sram_gw_n <= 1'b1;
      sram_bw_n <= 8'hFF;
      mem_data_oe <= 1'b0;
      fl_start_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          data_oe <= 1'b0;
          sram_oe_n <= 1'b1;
          if (launch)
          begin
            data_grant_master0_n <= stg_tag_q;
            data_grant_master1_n <= ~stg_tag_q;
            sram_addr <= stg_addr_q[SRAM_A_FIRST:SRAM_A_LAST];
            {cnt_q, beat_q} <= 5'h00;
            first_q <= 1'b1;
            act_burst_q <= stg_burst_q;
            act_lanes_q <= stg_lanes_q;
            if (stg_fl_q)
            begin
              fl_start_q <= 1'b1;
              state_q <= ST_FRD;
            end
            else if (stg_rd_q)
            begin
              sram_adsc_n <= 1'b0;
              sram_oe_n <= 1'b0;
              state_q <= ST_SRD;
            end
            else
              state_q <= ST_SWR;
          end
        end
        ST_SRD:
        begin
          if (cnt_q == 3'(SRAM_RD_CYC))
          begin
            // data and acknowledge leave on the same edge
            {data_par_o, data_upper_word_o, data_lower_word_o}
              <= mem_s2_q;
            data_oe <= 1'b1;
            ta_n <= 1'b0;
            cnt_q <= 3'h0;
            beat_q <= beat_q + 2'h1;
            if (last_beat)
              state_q <= ST_IDLE;
            else
              sram_adv_n <= 1'b0;
          end
          else
            cnt_q <= cnt_q + 3'h1;
        end
        ST_SWR:
        begin
          // wait until the master's beat has crossed the synchroniser
          if (cnt_q == 3'(WR_SETTLE_CYC))
          begin
            mem_data_o <= din_s2_q;
            mem_data_oe <= 1'b1;
            sram_bw_n <= ~act_lanes_q;
            sram_adsc_n <= ~first_q;
            sram_adv_n <= first_q;
            first_q <= 1'b0;
            ta_n <= 1'b0;
            cnt_q <= 3'h0;
            beat_q <= beat_q + 2'h1;
            if (last_beat)
              state_q <= ST_IDLE;
          end
          else
            cnt_q <= cnt_q + 3'h1;
        end
        ST_FRD:
        begin
          if (fl_done)
          begin
            {data_par_o, data_upper_word_o, data_lower_word_o}
              <= fl_word;
            data_oe <= 1'b1;
            ta_n <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // flash is read only, write strobe never moves
  always_ff @(posedge clk)
  begin
    flash_we_n <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  aack_pulse_a: assert property (!aack_n |=> aack_n)
    else $error("address acknowledge longer than one cycle");
  aack_cause_a: assert property (!aack_n |-> $past(ten_any)
    && $past(dec_valid))
    else $error("acknowledge without valid tenure");
  dgrant_excl_a: assert property (data_grant_master0_n
    || data_grant_master1_n)
    else $error("both data grants active");
  dgrant_tag_a: assert property ((!data_grant_master0_n
    || !data_grant_master1_n) |-> (!data_grant_master1_n == $past(stg_tag_q)))
    else $error("data grant to wrong master");
  beat_wait_a: assert property ((!data_grant_master0_n
    || !data_grant_master1_n) |-> ##1 ta_n [*3])
    else $error("beat acknowledged before data moved");
  sram_rd_lat_a: assert property (($fell(sram_adsc_n)
    && state_q == ST_SRD) |-> ##4 !ta_n)
    else $error("sram read beat latency wrong");
  flash_end_a: assert property ((state_q == ST_FRD && fl_done)
    |=> (!ta_n && state_q == ST_IDLE))
    else $error("flash read not single beat");
  retry_drop_a: assert property ((stage_v_q && s_artry && art_open)
    |=> !stage_v_q)
    else $error("retried transfer still pending");
  no_global_a: assert property (sram_gw_n && flash_we_n)
    else $error("global or flash write strobe driven");
  cover_burst_rd: cover property (state_q == ST_SRD && act_burst_q
    && last_beat && !ta_n);
  cover_write: cover property (state_q == ST_SWR && !ta_n);
  cover_flash: cover property (state_q == ST_FRD && fl_done);
  cover_retry: cover property (stage_v_q && s_artry && art_open);
endmodule // smc_top

// ---- testbench/smc_mem_model.sv ----
// memory models: flow-through sync sram and read-only flash
`timescale 1ns/100ps
module smc_mem_model
(
  // clock
  input wire logic clk,
  // sram pins
  input wire logic [17:0] sram_addr,
  input wire logic sram_adsc_n,
  input wire logic sram_adv_n,
  input wire logic [0:7] sram_bw_n,
  input wire logic sram_oe_n,
  // flash pins
  input wire logic [17:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  // shared data bus
  input wire logic [71:0] mem_data_o,
  input wire logic mem_data_oe,
  output logic [71:0] mem_data_i
);
  logic [71:0] mem_q [16]; // small window of sram words
  logic [3:0] ctr_q; // internal burst counter
  logic [3:0] wa; // word touched this cycle
  logic [71:0] last_q = '0; // released bus keeps toggling
  assign wa = !sram_adsc_n ? sram_addr[3:0] : ctr_q + {3'b0, !sram_adv_n};
  ////////////////////////////////////////////////////////////////////////
  // load, advance, byte write with parity
  always_ff @(posedge clk)
  begin
    if (!sram_adsc_n || !sram_adv_n) ctr_q <= wa;
    for (int k = 0; k < 8; k++)
      if (mem_data_oe && !sram_bw_n[k])
      begin
        mem_q[wa][63-8*k-:8] <= mem_data_o[63-8*k-:8];
        mem_q[wa][71-k] <= mem_data_o[71-k];
      end
    last_q <= mem_data_i;
  end
  // read mux; flash halfword on top two lanes
  always_comb
    if (!sram_oe_n) mem_data_i = mem_q[ctr_q];
    else if (!flash_ce_n && !flash_oe_n)
      mem_data_i = {8'h00, flash_addr[15:0] ^ 16'h5A5A, 48'h0};
    else mem_data_i = ~last_q;
endmodule // smc_mem_model

// ---- testbench/smc_top_tb.sv ----
// testbench: two processors on the controller, memories behind it
`timescale 1ns/100ps
module smc_top_tb;
  import smc_pkg::*;
  logic clk = 0, reset = 1, ts_n = 1, tbst_n = 1, artry_n = 1;
  logic addr_req_master0_n = 1, addr_req_master1_n = 1;
  logic [0:4] tt = 0;
  logic [0:2] tsiz = 0;
  logic [0:31] addr = 0, data_upper_word_i = 0, data_lower_word_i = 0;
  logic [0:31] data_upper_word_o, data_lower_word_o;
  logic [0:7] data_par_i = 0, data_par_o, sram_bw_n;
  logic addr_grant_master0_n, addr_grant_master1_n, aack_n, ta_n, data_oe;
  logic data_grant_master0_n, data_grant_master1_n, sram_adsc_n, sram_adv_n;
  logic sram_gw_n, sram_oe_n, mem_data_oe, flash_ce_n, flash_oe_n, flash_we_n;
  logic [17:0] sram_addr, flash_addr;
  logic [71:0] mem_data_i, mem_data_o;
  int failures = 0, check_count = 0;
  logic [63:0] rd_q [4]; // read beats seen
  logic [0:7] rp_q [4]; // read parity seen
  smc_top i_dut (.*);
  smc_mem_model i_mem (.*);
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [71:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bounded wait for an active-low strobe, sampled mid-cycle
  task automatic wait_low(ref logic s, input int n, input bit must,
                          output bit ok);
    ok = 0;
    repeat (n)
    begin
      @(negedge clk);
      if (s === 1'b0) begin ok = 1; break; end
    end
    if (!ok && must) begin failures++; print_verdict; end
  endtask
  function automatic logic [0:7] par(input logic [63:0] d);
    for (int k = 0; k < 8; k++) par[k] = ~^d[63-8*k-:8];
  endfunction
  // four flash halfwords, lowest address in the top lanes
  function automatic logic [63:0] fword(input logic [31:0] a);
    for (int i = 0; i < 4; i++)
      fword[63-16*i-:16] = {a[16:3], i[1:0]} ^ 16'h5A5A;
  endfunction
  // address tenure; grant first, hold until acknowledge
  task automatic tenure(input bit m, input logic [4:0] t,
                        input logic [31:0] a, input bit b, r, ack);
    bit ok;
    if (m) addr_req_master1_n = 0; else addr_req_master0_n = 0;
    if (m) wait_low(addr_grant_master1_n, 20, 1, ok);
    else wait_low(addr_grant_master0_n, 20, 1, ok);
    ts_n = 0; tt = t; addr = a; tbst_n = !b;
    @(negedge clk) ts_n = 1;
    wait_low(aack_n, 12, 0, ok);
    if (m) addr_req_master1_n = 1; else addr_req_master0_n = 1;
    check("aack", ok, ack);
    if (r) begin artry_n = 0; repeat (2) @(negedge clk); artry_n = 1; end
  endtask
  // data tenure of 1 or 4 beats, each paced by ta
  task automatic data_phase(input bit m, b, input logic [63:0] d);
    bit ok;
    if (m) wait_low(data_grant_master1_n, 40, 1, ok);
    else wait_low(data_grant_master0_n, 40, 1, ok);
    for (int i = 0; i < (b ? 4 : 1); i++)
    begin
      {data_upper_word_i, data_lower_word_i} = d + i;
      data_par_i = par(d + i);
      wait_low(ta_n, 40, 1, ok);
      rd_q[i] = {data_upper_word_o, data_lower_word_o};
      rp_q[i] = data_par_o;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_sram; // single write by one master, read by other
    tenure(0, TT_WR_FLUSH, 32'h4000_0020, 0, 0, 1);
    data_phase(0, 0, 64'h0123_4567_89AB_CDEF);
    tenure(1, TT_RD, 32'h4000_0020, 0, 0, 1);
    data_phase(1, 0, 64'h0);
    check("sram", {rp_q[0], rd_q[0]}, {par(64'h0123_4567_89AB_CDEF),
      64'h0123_4567_89AB_CDEF});
    // one byte at offset 3 must touch lane 3 only
    tsiz = 3'h1;
    tenure(0, TT_WR_FLUSH, 32'h4000_0023, 0, 0, 1);
    data_phase(0, 0, 64'hFFFF_FFFF_FFFF_FFFF);
    tsiz = 3'h0;
    tenure(1, TT_RD, 32'h4000_0020, 0, 0, 1);
    data_phase(1, 0, 64'h0);
    check("byte", {rp_q[0], rd_q[0]}, {par(64'h0123_45FF_89AB_CDEF),
      64'h0123_45FF_89AB_CDEF});
  endtask
  task automatic t_burst; // linear four-beat write then read
    tenure(1, TT_WR_KILL, 32'h4000_0040, 1, 0, 1);
    data_phase(1, 1, 64'hFEDC_BA98_7654_3210);
    tenure(0, TT_RD_MOD, 32'h4000_0040, 1, 0, 1);
    data_phase(0, 1, 64'h0);
    for (int i = 0; i < 4; i++)
      check("burst", rd_q[i], 64'hFEDC_BA98_7654_3210 + i);
  endtask
  task automatic t_flash; // reset vector fetch assembled from flash
    tenure(1, TT_RD, RESET_VECTOR, 0, 0, 1);
    data_phase(1, 0, 64'h0);
    check("flash", rd_q[0], fword(RESET_VECTOR));
  endtask
  task automatic t_contend; // both request, grants alternate within a round, so each round's first winner repeats
    bit w, p;
    for (int n = 0; n < 2; n++)
    begin
      // let released requests clear the synchronisers first
      repeat (4) @(negedge clk);
      addr_req_master0_n = 0;
      addr_req_master1_n = 0;
      repeat (8) @(negedge clk);
      w = (addr_grant_master1_n === 1'b0);
      if (n) check("winner", w, p);
      tenure(w, 5'h00, SRAM_BASE, 0, 0, 1);
      tenure(!w, 5'h00, SRAM_BASE, 0, 0, 1);
      p = w;
    end
  endtask
  task automatic t_refuse; // retry cancels, flash write and hole refused
    bit ok;
    tenure(0, TT_RD, 32'h4000_0020, 0, 1, 1);
    wait_low(data_grant_master0_n, 40, 0, ok);
    check("retry", ok, 0);
    tenure(0, TT_WR_FLUSH, FLASH_BASE, 0, 0, 0);
    tenure(1, TT_RD, 32'h1000_0000, 0, 0, 0);
    check("we", {sram_gw_n, flash_we_n}, 2'b11);
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    check("idle", {aack_n, ta_n, addr_grant_master0_n, data_oe}, 4'he);
    reset = 0;
    @(negedge clk);
    t_sram;
    t_burst;
    t_flash;
    t_contend;
    t_refuse;
    print_verdict;
  end
endmodule // smc_top_tb
